// >>> idf_pkg.sv
// constants for the input debounce filter
package idf_pkg;

    // clock period in ns
    localparam int CLK_NS = 8;

    // debounce times in ns, sixteen steps from shortest to longest
    localparam int DB_MIN_NS = 500;
    localparam int DB_MAX_NS = 25500000;
    localparam int DB_STEPS  = 16;
    localparam int CNT_W     = 22;

    // time table in ns; each entry rounds up to whole cycles
    localparam int DB_NS [0:15] = '{
        500, 1000, 2000, 5000, 10000, 20000, 50000, 100000,
        200000, 500000, 1000000, 2000000, 5000000, 10000000,
        20000000, 25500000};

    // apb register byte offsets
    localparam logic [11:0] CTRL_ADDR = 12'h000;
    localparam logic [11:0] STAT_ADDR = 12'h004;

    // control field positions
    localparam int CTRL_SEL_LO = 0;
    localparam int CTRL_MODE   = 4;
    localparam int CTRL_INV    = 5;
    localparam int CTRL_BYP    = 6;

    // control value after reset: shortest time, after-stable mode
    localparam logic [6:0] CTRL_RST = 7'h00;

    // cycle count of a debounce time given in ns
    function automatic logic [CNT_W-1:0] idf_cycles(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        if (c < 1)
            c = 1;
        return c[CNT_W-1:0];
    endfunction

endpackage

// >>> idf_filter.sv
// input debounce filter with apb control, one channel
`timescale 1ns/1ns
`default_nettype none
// How it works
// - after-stable: hold output until input stable
// - after-stable: rise passes after full time
// - after-stable: fall passes after full time
// - after-stable: short disturbances fully rejected
// - every input change restarts the counter
// - before-stable: follow edge, then lock
// - before-stable: accept edge only after stability
// - before-stable: unstable input holds output
// - before-stable: edge after stability passes at once
// - before-stable: first glitch of burst passes
// - software bypass passes transitions directly
// - sixteen selectable debounce times
// - optional input inversion before the filter
// - bypass ignores time, passes input after the optional inversion
module idf_filter
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        sig_in,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             filt_out,
    output logic             edge_pulse
);
    import idf_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic             sync1;
        logic             sync2;
        logic             prev;
        logic [CNT_W-1:0] cnt;
        logic             stable;
        logic             filt;
        logic             edge_p;
        logic [6:0]       ctrl;
        logic [31:0]      rdata;
        logic             rdy;
        logic             err;
    } idf_state_t;

    idf_state_t st;
    idf_state_t next_st;

    logic             cond;
    logic [CNT_W-1:0] limit;
    logic             hit;
    logic             acc;
    logic             take;

    // ************************************************************
    // combinational next state
    // ************************************************************
    always_comb
    begin
        next_st = st;
        next_st.edge_p = 1'b0;
        limit = idf_cycles(DB_NS[st.ctrl[CTRL_SEL_LO +: 4]]);
        next_st.sync1 = sig_in;
        next_st.sync2 = st.sync1;
        cond = st.sync2 ^ st.ctrl[CTRL_INV];
        next_st.prev = cond;
        hit = 1'b0;
        if (cond != st.prev)
        begin
            next_st.cnt = '0;
            next_st.stable = 1'b0;
        end
        else if (!st.stable)
        begin
            next_st.cnt = st.cnt + 1'b1;
            if (st.cnt + 1'b1 >= limit - 1'b1)
            begin
                next_st.stable = 1'b1;
                hit = 1'b1;
            end
        end
        acc = st.filt;
        if (st.ctrl[CTRL_BYP])
        begin
            acc = cond;
        end
        else if (st.ctrl[CTRL_MODE])
        begin
            // burst after first edge is locked out
            if (cond != st.prev && st.stable)
                acc = cond;
        end
        else
        begin
            if (hit)
                acc = cond;
        end
        next_st.filt = acc;
        // one pulse per accepted rise only
        next_st.edge_p = acc & ~st.filt;
        // apb slave, one wait state so that pready comes from a flop
        // read data and error are staged in the first access cycle
        take = psel & penable & ~st.rdy;
        next_st.rdy = take;
        next_st.err = 1'b0;
        next_st.rdata = '0;
        if (take)
        begin
            case (paddr)
                CTRL_ADDR:
                    next_st.rdata = {25'h0000000, st.ctrl};
                STAT_ADDR:
                    next_st.rdata = {29'h00000000, st.stable, cond, st.filt};
                default:
                    next_st.err = 1'b1;
            endcase
        end
        // the write lands only on the edge that sees pready high,
        // so a master that aborts early leaves the control untouched
        if (psel & penable & st.rdy & pwrite & (paddr == CTRL_ADDR))
        begin
            next_st.ctrl = pwdata[6:0];
        end
        if (sys_rst)
        begin
            next_st = '0;
            next_st.filt = 1'b0;
            next_st.ctrl = CTRL_RST;
        end
    end

    always_ff @(posedge clk)
    begin
        st <= next_st;
    end

    assign prdata = st.rdata;
    assign pready = st.rdy;
    assign pslverr = st.err;
    assign filt_out = st.filt;
    assign edge_pulse = st.edge_p;

    // ************************************************************
    // checks
    // ************************************************************
    sequence chg_s;
        cond != st.prev;
    endsequence

    edge_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
        edge_pulse |-> filt_out && !$past(filt_out))
        else $error("edge pulse without rise");

    after_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        (!st.ctrl[CTRL_BYP] && !st.ctrl[CTRL_MODE] && !hit)
        |=> st.filt == $past(st.filt))
        else $error("after-stable output moved early");

    after_rise_a: assert property (@(posedge clk) disable iff (sys_rst)
        (!st.ctrl[CTRL_BYP] && !st.ctrl[CTRL_MODE] && hit && cond)
        |=> st.filt)
        else $error("after-stable rise missed");

    after_fall_a: assert property (@(posedge clk) disable iff (sys_rst)
        (!st.ctrl[CTRL_BYP] && !st.ctrl[CTRL_MODE] && hit && !cond)
        |=> !st.filt)
        else $error("after-stable fall missed");

    cnt_restart_a: assert property (@(posedge clk) disable iff (sys_rst)
        chg_s |=> st.cnt == '0 && !st.stable)
        else $error("count not restarted");

    before_pass_a: assert property (@(posedge clk) disable iff (sys_rst)
        (!st.ctrl[CTRL_BYP] && st.ctrl[CTRL_MODE] && st.stable) ##0 chg_s
        |=> st.filt == $past(cond))
        else $error("before-stable edge not passed");

    before_lock_a: assert property (@(posedge clk) disable iff (sys_rst)
        (!st.ctrl[CTRL_BYP] && st.ctrl[CTRL_MODE] && !st.stable)
        |=> st.filt == $past(st.filt))
        else $error("before-stable changed while locked");

    bypass_a: assert property (@(posedge clk) disable iff (sys_rst)
        st.ctrl[CTRL_BYP] && $stable(st.ctrl) |=> st.filt == $past(cond))
        else $error("bypass not following input");

    reset_low_a: assert property (@(posedge clk)
        sys_rst |=> !filt_out)
        else $error("output not low after reset");

    reset_ctrl_a: assert property (@(posedge clk)
        sys_rst |=> st.ctrl == CTRL_RST)
        else $error("control not cleared by reset");

    sync_chain_a: assert property (@(posedge clk) disable iff (sys_rst)
        st.sync2 == $past(st.sync1))
        else $error("synchroniser chain broken");

    sequence after_mode_s;
        !st.ctrl[CTRL_BYP] && !st.ctrl[CTRL_MODE];
    endsequence

    sequence before_mode_s;
        !st.ctrl[CTRL_BYP] && st.ctrl[CTRL_MODE];
    endsequence

    sequence filt_move_s;
        $changed(st.filt);
    endsequence

    after_hit_a: assert property (@(posedge clk) disable iff (sys_rst)
        after_mode_s ##1 filt_move_s |-> $past(hit))
        else $error("after-stable moved without stability");

    before_stable_a: assert property (@(posedge clk) disable iff (sys_rst)
        before_mode_s ##1 filt_move_s |-> $past(st.stable && cond != st.prev))
        else $error("before-stable moved while locked");

    // every accepted rise gives a pulse
    rise_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
        filt_out && !$past(filt_out) |-> edge_pulse)
        else $error("accepted rise without pulse");

    edge_once_a: assert property (@(posedge clk) disable iff (sys_rst)
        edge_pulse |=> !edge_pulse)
        else $error("edge pulse too long");

    // ************************************************************
    // bus checks
    // ************************************************************
    // answer one cycle into the access phase
    rdy_answer_a: assert property (@(posedge clk) disable iff (sys_rst)
        psel && penable && !pready |=> pready)
        else $error("bus answer late");

    // ready is a single-cycle pulse
    rdy_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
        pready |=> !pready)
        else $error("ready held too long");

    // error only together with ready
    err_rdy_a: assert property (@(posedge clk) disable iff (sys_rst)
        pslverr |-> pready)
        else $error("error without ready");

    // unmapped address answers with an error
    err_map_a: assert property (@(posedge clk) disable iff (sys_rst)
        psel && penable && !pready && paddr != CTRL_ADDR
        && paddr != STAT_ADDR |=> pslverr)
        else $error("unmapped address not refused");

    // control write lands on the completing edge
    write_land_a: assert property (@(posedge clk) disable iff (sys_rst)
        psel && penable && pready && pwrite && paddr == CTRL_ADDR
        |=> st.ctrl == $past(pwdata[6:0]))
        else $error("control write lost");

endmodule // idf_filter
`default_nettype wire

// >>> idf_source.sv
// signal source model: clean level or contact chatter
`timescale 1ns/1ns
`default_nettype none
module idf_source
(
    input  wire logic clk,
    input  wire logic want,
    input  wire logic chatter,
    output var  logic sig
);
    logic [1:0] ph;
    initial ph = 2'h0;
    initial sig = 1'b0;
    // ****************************************
    // chatter toggles every 4 cycles, so it never looks stable
    // ****************************************
    always @(posedge clk)
    begin
        ph <= ph + 2'h1;
        sig <= chatter ? ((ph == 2'h3) ? ~sig : sig) : want;
    end
endmodule // idf_source
`default_nettype wire

// >>> input_debounce_filter_test.sv
// testbench for the input debounce filter
`timescale 1ns/1ns
`default_nettype none
module input_debounce_filter_test;
    import idf_pkg::*;
    typedef struct {logic [6:0] c; logic l; int h; logic e;} idf_row_t;
    logic        clk = 1'b0, sys_rst = 1'b1, want = 1'b0, chatter = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        sig_in, pready, pslverr, filt_out, edge_pulse;
    int          error_cnt = 0, n_compared = 0, cyc = 0, edges = 0, n;
    idf_row_t    rows [8];

    idf_source src (.clk(clk), .want(want), .chatter(chatter),
        .sig(sig_in));
    idf_filter dut (.clk(clk), .sys_rst(sys_rst), .sig_in(sig_in),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .filt_out(filt_out), .edge_pulse(edge_pulse));

    initial
    begin
        forever #4 clk = ~clk;
    end

    task test_done;
        $display("errors %0d compared %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task chk(input logic ok, input string m);
        n_compared++;
        if (!ok)
        begin
            error_cnt++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask

    task wait_n(input int k);
        repeat (k) @(posedge clk);
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        i = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            i++;
        end
        while (pready !== 1'b1 && i < 50);
        rd = prdata;
        er = pslverr;
        chk(i < 50, "no bus answer");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // ****************************************
    // hang guard and accepted edge count
    // ****************************************
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (edge_pulse === 1'b1)
            edges <= edges + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            test_done;
        end
    end

    initial
    begin
        // step 0 is 63 cycles, step 1 is 125 cycles
        rows = '{'{7'h00, 1, 20, 0}, '{7'h00, 1, 70, 1},
                 '{7'h00, 0, 40, 1}, '{7'h00, 0, 50, 0},
                 '{7'h01, 1, 100, 0}, '{7'h01, 1, 40, 1},
                 '{7'h40, 0, 8, 0}, '{7'h60, 0, 8, 1}};
        wait_n(10);
        sys_rst <= 1'b0;
        @(posedge clk);
        chk(filt_out === 1'b0 && edge_pulse === 1'b0, "reset out");
        apb(1'b0, CTRL_ADDR, 32'h0);
        chk(rd === 32'h0 && er === 1'b0, "ctrl reset");
        wait_n(80);
        for (int k = 0; k < 8; k++)
        begin
            apb(1'b1, CTRL_ADDR, {25'h0, rows[k].c});
            want <= rows[k].l;
            wait_n(rows[k].h);
            chk(filt_out === rows[k].e, "row");
        end
        // chatter shorter than the time must vanish entirely
        apb(1'b1, CTRL_ADDR, 32'h0);
        wait_n(100);
        n = edges;
        chatter <= 1'b1;
        wait_n(200);
        chatter <= 1'b0;
        wait_n(100);
        chk(filt_out === 1'b0 && edges == n, "chatter passed");
        // first glitch passes, the rest of the burst is locked out
        apb(1'b1, CTRL_ADDR, 32'h10);
        wait_n(100);
        n = edges;
        want <= 1'b1;
        wait_n(8);
        chk(filt_out === 1'b1, "no prompt rise");
        chatter <= 1'b1;
        wait_n(40);
        chk(filt_out === 1'b1, "lock broken");
        chatter <= 1'b0;
        wait_n(100);
        chk(filt_out === 1'b1 && edges == n + 1, "burst count");
        want <= 1'b0;
        wait_n(8);
        chk(filt_out === 1'b0, "late fall");
        apb(1'b0, 12'h008, 32'h0);
        chk(er === 1'b1, "unmapped accepted");
        // status while bypassed and inverted, then a reset in mid-run
        apb(1'b1, CTRL_ADDR, 32'h60);
        wait_n(4);
        apb(1'b0, STAT_ADDR, 32'h0);
        chk(rd === 32'h3 && er === 1'b0, "status");
        sys_rst <= 1'b1;
        wait_n(2);
        sys_rst <= 1'b0;
        @(posedge clk);
        chk(filt_out === 1'b0 && pready === 1'b0, "mid reset out");
        apb(1'b0, CTRL_ADDR, 32'h0);
        chk(rd === 32'h0 && er === 1'b0, "mid reset ctrl");
        test_done;
    end
endmodule // input_debounce_filter_test
`default_nettype wire
